/* ride_pkg.sv */
// Constants and types for the instruction decode/execute unit.
// Assumes a single 100 MHz clock and an APB slave front end.
package ride_pkg;

  localparam int RIDE_DW = 32;

  // Bit label 0 is the MSB of a word; map a label to a vector index
  function automatic int ride_vbit(input int lbl);
    return RIDE_DW - 1 - lbl;
  endfunction

  // Instruction fields, as label ranges turned into vector indices
  localparam int OPC_HI = ride_vbit(0);
  localparam int OPC_LO = ride_vbit(5);
  localparam int RD_HI  = ride_vbit(6);
  localparam int RD_LO  = ride_vbit(10);
  localparam int RA_HI  = ride_vbit(11);
  localparam int RA_LO  = ride_vbit(15);
  localparam int RB_HI  = ride_vbit(16);
  localparam int RB_LO  = ride_vbit(20);
  localparam int IMM_HI = ride_vbit(16);
  localparam int PUT_B  = ride_vbit(16);
  localparam int NBK_B  = ride_vbit(17);
  localparam int CTL_B  = ride_vbit(18);
  localparam int MSR_C  = ride_vbit(29);
  localparam int MSR_SE = ride_vbit(27);
  localparam int MSR_CC = ride_vbit(0);
  localparam int SEX8_B = ride_vbit(24);
  localparam int SEX16B = ride_vbit(16);

  // Opcodes and function codes
  localparam logic [5:0] OP_ADDK = 6'h05;
  localparam logic [5:0] OP_MUL  = 6'h10;
  localparam logic [5:0] OP_BS   = 6'h11;
  localparam logic [5:0] OP_DIV  = 6'h12;
  localparam logic [5:0] OP_FPU  = 6'h16;
  localparam logic [5:0] OP_STRM = 6'h1B;
  localparam logic [5:0] OP_SH1  = 6'h24;
  localparam logic [5:0] OP_SPR  = 6'h25;
  localparam logic [5:0] OP_IMM  = 6'h2C;
  localparam logic [10:0] FN_CMP  = 11'h001;
  localparam logic [10:0] FN_UNSIGNED_COMPARE = 11'h003;
  localparam logic [10:0] FN_DIVU = 11'h002;
  localparam logic [10:0] FN_PAT  = 11'h400;
  localparam logic [15:0] FN_SRA = 16'h0001;
  localparam logic [15:0] FN_SRC = 16'h0021;
  localparam logic [15:0] FN_SRL = 16'h0041;
  localparam logic [15:0] FN_SX8 = 16'h0060;
  localparam logic [15:0] FN_SX16 = 16'h0061;
  localparam logic [15:0] FN_WIC = 16'h0068;
  localparam logic [15:0] FN_WDC = 16'h0064;

  // Special register numbers
  localparam logic [13:0] SPR_PC  = 14'h0000;
  localparam logic [13:0] SPR_MSR = 14'h0001;
  localparam logic [13:0] SPR_EAR = 14'h0003;
  localparam logic [13:0] SPR_ESR = 14'h0005;
  localparam logic [13:0] SPR_FSR = 14'h0007;
  localparam logic [13:0] SPR_BTR = 14'h000B;
  localparam logic [13:0] SPR_VER = 14'h2000;
  localparam logic [13:0] SPR_VEND = 14'h200B;

  // APB byte offsets
  localparam logic [7:0] A_INSTR  = 8'h00;
  localparam logic [7:0] A_GSEL   = 8'h04;
  localparam logic [7:0] A_GDATA  = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_CFG    = 8'h10;

  // Option enables: mul, div, barrel, fpu
  localparam logic [3:0] CFG_RST = 4'hF;
  localparam logic [31:0] PC_STEP = 32'h0000_0004;

  typedef enum logic {ST_IDLE, ST_EXEC} ride_state_e;

  typedef struct packed {
    ride_state_e       st;
    logic [31:0][31:0] gpr;
    logic [31:0]       instr;
    logic [31:0]       pc;
    logic [31:0]       prdata;
    logic [31:0]       out_data;
    logic [15:0]       imm_hi;
    logic [4:0]        gsel;
    logic [3:0]        cfg;
    logic              imm_vld;
    logic              carry;
    logic              serr;
    logic              illegal;
    logic              afault;
    logic              out_write;
    logic              out_ctl;
  } ride_state_s;

endpackage

/* ride_core.sv */
// Instruction decode/execute unit with stream link ports.
// Assumes an APB master and a peer that muxes the selected link.
// Function
// - Big-endian; bit label 0 is the word MSB, 31 the LSB.
// - Word, half-word and byte types, label 0 most significant.
// - Each instruction is one 32-bit word, register or immediate.
// - 16-bit immediate; widened to 32 bits after a prefix.
// - Opcode 0-5, dest 6-10, src a 11-15, src b 16-20, imm 16-31.
// - Arithmetic is signed unless unsigned or float.
// - Add/reverse-subtract with carry forms; immediates sign-extended.
// - Compares write rsub result with MSB forced by b>=a.
// - Barrel shifts by register or 5-bit immediate, proper fill.
// - Divide b by a; function 2 unsigned, zero signed.
// - One-bit right shifts move LSB to carry; fill by kind.
// - Byte find returns first matching lane 1..4, else 0.
// - Pattern equal/not-equal write 1 or 0.
// - Stream ops select a port by a 3-bit field.
// - Blocking read stalls; data read flags control words.
// - Control read flags words not marked control.
// - Non-blocking read never stalls; carry = not available.
// - Writes send source a; blocking waits, non-blocking sets carry.
// - Special register numbering, version block at 8192.
// - Memory accesses must be aligned to their size.
// - Register zero reads zero; writes to it are dropped.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module ride_core
  import ride_pkg::*;
#(
  parameter logic [31:0] VERSION_WORD = 32'h0000_0001  // Arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [2:0]  STREAM_PORT_SELECT,
  input  wire logic [31:0] IN_DATA,
  input  wire logic        IN_WORD_IS_CONTROL,
  input  wire logic        IN_WORD_AVAILABLE,
  output logic             IN_READ,
  output logic      [31:0] OUT_DATA,
  output logic             OUT_IS_CONTROL,
  output logic             OUT_WRITE,
  input  wire logic        OUT_LINK_FULL
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Float ordering key; -0 folds onto +0
  function automatic logic [31:0] fkey(input logic [31:0] x);
    logic [31:0] z;
    z = (x[30:0] == 31'h0) ? 32'h0 : x;
    return z[31] ? ~z : (z | 32'h8000_0000);
  endfunction

  function automatic logic is_nan(input logic [31:0] x);
    return (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
  endfunction

  // First equal lane from the most significant byte
  function automatic logic [31:0] bfind(input logic [31:0] a,
                                        input logic [31:0] b);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v == 32'h0 && a[8*i +: 8] == b[8*i +: 8]) begin
        v = 32'(4 - i);
      end
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------
  ride_state_s r, s;
  logic [31:0] ins, a, b, opb, imm, res, machine_status_reg, rdv;
  logic [32:0] sum;
  logic [5:0]  op;
  logic [4:0]  rdi;
  logic [10:0] fn;
  logic        we, done, cin, fa, fb, lt, eq, unord;
  logic        setup, acc, bad_addr, err, in_read, put_go;
  logic [2:0]  fsel;

  always_comb begin
    ins  = r.instr;
    op   = ins[OPC_HI:OPC_LO];
    rdi  = ins[RD_HI:RD_LO];
    fn   = ins[10:0];
    a    = r.gpr[ins[RA_HI:RA_LO]];
    b    = r.gpr[ins[RB_HI:RB_LO]];
    // Prefix supplies the upper half, else sign-extend
    imm  = r.imm_vld ? {r.imm_hi, ins[IMM_HI:0]}
                     : {{16{ins[IMM_HI]}}, ins[IMM_HI:0]};
    opb  = op[3] ? imm : b;
    machine_status_reg  = 32'h0;
    machine_status_reg[MSR_C]  = r.carry;
    machine_status_reg[MSR_SE] = r.serr;
    machine_status_reg[MSR_CC] = r.carry;
  end

  // ---------------------------------------------------------------
  // Next state: APB access first, then execution (sets win)
  // ---------------------------------------------------------------
  always_comb begin
    s        = r;
    res      = 32'h0;
    sum      = 33'h0;
    cin      = 1'b0;
    we       = 1'b0;
    done     = 1'b1;
    in_read  = 1'b0;
    put_go   = 1'b0;
    fsel     = fn[6:4];
    fa       = is_nan(a);
    fb       = is_nan(opb);
    unord    = fa | fb;
    lt       = fkey(opb) < fkey(a);
    eq       = fkey(opb) == fkey(a);
    s.out_write = 1'b0;
    setup    = PSEL & ~PENABLE;
    acc      = PSEL & PENABLE;
    bad_addr = !(PADDR inside {A_INSTR, A_GSEL, A_GDATA, A_STATUS,
                               A_CFG});
    // A new instruction while one is running is refused
    err      = bad_addr | (PWRITE & (PADDR == A_INSTR)
                           & (r.st != ST_IDLE));
    rdv      = r.gpr[r.gsel];
    // Read data is captured in the setup cycle
    if (setup) begin
      case (PADDR)
        A_INSTR:  s.prdata = r.instr;
        A_GSEL:   s.prdata = {27'h0, r.gsel};
        A_GDATA:  s.prdata = rdv;
        A_STATUS: s.prdata = {27'h0, r.afault, r.illegal, r.serr,
                              r.carry, (r.st != ST_IDLE)};
        A_CFG:    s.prdata = {28'h0, r.cfg};
        default:  s.prdata = 32'h0;
      endcase
    end
    if (acc && PWRITE && !err) begin
      case (PADDR)
        A_INSTR: begin
          s.instr = PWDATA;
          s.st    = ST_EXEC;
        end
        A_GSEL:  s.gsel = PWDATA[4:0];
        A_GDATA: begin
          if (r.gsel != 5'h0) begin
            s.gpr[r.gsel] = PWDATA;
          end
        end
        A_STATUS: begin
          // Write one to clear the sticky flags
          if (PWDATA[2]) s.serr    = 1'b0;
          if (PWDATA[3]) s.illegal = 1'b0;
          if (PWDATA[4]) s.afault  = 1'b0;
        end
        A_CFG:   s.cfg = PWDATA[3:0];
        default: s.cfg = r.cfg;
      endcase
    end

    // Execution of the latched instruction
    if (r.st == ST_EXEC) begin
      case (op) inside
        6'b00????: begin
          // Add / reverse-subtract family
          cin = op[1] ? r.carry : op[0];
          sum = {1'b0, opb} + {1'b0, (op[0] ? ~a : a)} + 33'(cin);
          res = sum[31:0];
          we  = 1'b1;
          if (!op[2]) s.carry = sum[32];
          if (op == OP_ADDK && fn == FN_CMP) begin
            res[31] = !($signed(b) >= $signed(a));
          end else if (op == OP_ADDK && fn == FN_UNSIGNED_COMPARE) begin
            res[31] = !(b >= a);
          end else if (!op[3] && fn != 11'h0) begin
            we = 1'b0;
            s.illegal = 1'b1;
          end
        end
        6'b01?000: begin
          we  = r.cfg[0];
          res = a * opb;
          s.illegal = s.illegal | !r.cfg[0];
        end
        6'b01?001: begin
          // Barrel shift by register or 5-bit immediate
          we = r.cfg[2] && (fn[10:9] != 2'b11);
          s.illegal = s.illegal | !we;
          case (fn[10:9])
            2'b00:   res = a >> opb[4:0];
            2'b01:   res = 32'($signed(a) >>> opb[4:0]);
            default: res = a << opb[4:0];
          endcase
        end
        OP_DIV: begin
          // Quotient is b over a; zero divisor gives zero
          we = r.cfg[1];
          s.illegal = s.illegal | !r.cfg[1];
          if (a == 32'h0) begin
            res = 32'h0;
          end else if (fn == FN_DIVU) begin
            res = b / a;
          end else begin
            res = 32'($signed(b) / $signed(a));
          end
        end
        OP_FPU: begin
          // Only compares are built; b is compared against a
          we = r.cfg[3] && fn[10:7] == 4'b0100 && fsel != 3'd7;
          s.illegal = s.illegal | !we;
          case (fsel)
            3'd0:    res = 32'(unord);
            3'd1:    res = 32'(!unord && lt);
            3'd2:    res = 32'(!unord && eq);
            3'd3:    res = 32'(!unord && (lt || eq));
            3'd4:    res = 32'(!unord && !lt && !eq);
            3'd5:    res = 32'(!unord && !eq);
            default: res = 32'(!unord && !lt);
          endcase
        end
        OP_STRM: begin
          s.out_ctl = r.out_ctl;
          if (!ins[PUT_B]) begin
            if (IN_WORD_AVAILABLE) begin
              in_read = 1'b1;
              res     = IN_DATA;
              we      = 1'b1;
              // Word type must match the read kind
              if (IN_WORD_IS_CONTROL != ins[CTL_B]) s.serr = 1'b1;
              if (ins[NBK_B]) s.carry = 1'b0;
            end else if (ins[NBK_B]) begin
              s.carry = 1'b1;
            end else begin
              done = 1'b0;
            end
          end else begin
            if (!OUT_LINK_FULL) begin
              put_go      = 1'b1;
              s.out_write = 1'b1;
              s.out_data  = a;
              s.out_ctl   = ins[CTL_B];
              if (ins[NBK_B]) s.carry = 1'b0;
            end else if (ins[NBK_B]) begin
              s.carry = 1'b1;
            end else begin
              done = 1'b0;
            end
          end
        end
        6'b100000, 6'b100001, 6'b100010, 6'b100011: begin
          we = 1'b1;
          if (fn == FN_PAT && op[1:0] == 2'b00) begin
            res = bfind(a, b);
          end else if (fn == FN_PAT) begin
            // Compares source a with source b; opcode bit 0 selects not-equal
            res = 32'((a == b) ^ op[0]);
          end else begin
            case (op[1:0])
              2'b00:   res = a | b;
              2'b01:   res = a & b;
              2'b10:   res = a ^ b;
              default: res = a & ~b;
            endcase
          end
        end
        6'b1010??: begin
          we = 1'b1;
          case (op[1:0])
            2'b00:   res = a | imm;
            2'b01:   res = a & imm;
            2'b10:   res = a ^ imm;
            default: res = a & ~imm;
          endcase
        end
        OP_SH1: begin
          we = 1'b1;
          case (ins[IMM_HI:0])
            // Label 31 (vector bit 0) leaves into carry
            FN_SRA:  res = {a[31], a[31:1]};
            FN_SRC:  res = {r.carry, a[31:1]};
            FN_SRL:  res = {1'b0, a[31:1]};
            FN_SX8:  res = {{24{a[SEX8_B]}}, a[SEX8_B:0]};
            FN_SX16: res = {{16{a[SEX16B]}}, a[SEX16B:0]};
            default: we = 1'b0;
          endcase
          if (ins[IMM_HI:0] inside {FN_SRA, FN_SRC, FN_SRL}) begin
            s.carry = a[0];
          end else if (!(ins[IMM_HI:0] inside {FN_SX8, FN_SX16,
                                               FN_WIC, FN_WDC})) begin
            s.illegal = 1'b1;
          end
        end
        OP_SPR: begin
          if (ins[15:14] == 2'b10) begin
            we = 1'b1;
            case (ins[13:0]) inside
              SPR_PC:  res = r.pc;
              SPR_MSR: res = machine_status_reg;
              SPR_EAR, SPR_ESR, SPR_FSR, SPR_BTR: res = 32'h0;
              [SPR_VER:SPR_VEND]:
                res = (ins[13:0] == SPR_VER) ? VERSION_WORD : 32'h0;
              default: begin
                we = 1'b0;
                s.illegal = 1'b1;
              end
            endcase
          end else if (ins[15:14] == 2'b11 && ins[13:0] == SPR_MSR) begin
            s.carry = a[MSR_C];
            s.serr  = a[MSR_SE] | s.serr;
          end else if (ins[15:14] != 2'b11) begin
            s.illegal = 1'b1;
          end
        end
        OP_IMM: s.imm_hi = ins[IMM_HI:0];
        6'b11????: begin
          // No memory port; misaligned half-word and word accesses set afault, all others set illegal
          res = a + opb;
          if ((op[1:0] == 2'b01 && res[0]) ||
              (op[1:0] == 2'b10 && res[1:0] != 2'b00)) begin
            s.afault = 1'b1;
          end else begin
            s.illegal = 1'b1;
          end
          res = 32'h0;
        end
        default: s.illegal = 1'b1;
      endcase
      if (we && rdi != 5'h0) begin
        s.gpr[rdi] = res;
      end
      if (done) begin
        s.st      = ST_IDLE;
        s.pc      = r.pc + PC_STEP;
        s.imm_vld = (op == OP_IMM);
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r     <= '0;
      r.cfg <= CFG_RST;
    end else begin
      r <= s;
    end
  end

  // Outputs
  assign PRDATA             = r.prdata;
  assign PREADY             = 1'b1;
  assign PSLVERR            = acc & err;
  assign STREAM_PORT_SELECT = r.instr[2:0];
  assign IN_READ            = in_read;
  assign OUT_DATA           = r.out_data;
  assign OUT_IS_CONTROL     = r.out_ctl;
  assign OUT_WRITE          = r.out_write;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic is_strm, is_get;
  assign is_strm = (r.st == ST_EXEC) && (op == OP_STRM);
  assign is_get  = is_strm && !ins[PUT_B];

  reg_zero_a: assert property (r.gpr[0] == 32'h0)
    else $error("register zero is not zero");
  get_stall_a: assert property (
    is_get && !ins[NBK_B] && !IN_WORD_AVAILABLE
    |=> r.st == ST_EXEC && $stable(r.gpr))
    else $error("blocking read did not stall");
  nget_carry_a: assert property (
    is_get && ins[NBK_B] |=> r.carry == !$past(IN_WORD_AVAILABLE)
    && r.st == ST_IDLE)
    else $error("non-blocking read carry wrong");
  put_send_a: assert property (
    put_go |=> OUT_WRITE && OUT_DATA == $past(a) ##1 !OUT_WRITE)
    else $error("write not sent once");
  nput_carry_a: assert property (
    is_strm && ins[PUT_B] && ins[NBK_B]
    |=> r.carry == $past(OUT_LINK_FULL))
    else $error("non-blocking write carry wrong");
  cget_err_a: assert property (
    in_read && ins[CTL_B] && !IN_WORD_IS_CONTROL |=> r.serr)
    else $error("control read type error lost");
  opt_gate_a: assert property (
    r.st == ST_EXEC && op == OP_DIV && !r.cfg[1]
    |=> r.illegal && $stable(r.gpr))
    else $error("disabled divider executed");
  start_exec_a: assert property (
    acc && PWRITE && PADDR == A_INSTR && r.st == ST_IDLE
    |=> r.st == ST_EXEC ##1 r.pc != $past(r.pc) || r.st == ST_EXEC)
    else $error("instruction did not start");
  align_chk_a: assert property (
    r.st == ST_EXEC && op == 6'b110010 && sum == 33'h0
    && (a + opb) % 4 != 0 |=> r.afault)
    else $error("misaligned word not flagged");

  stall_c: cover property (is_get && !IN_WORD_AVAILABLE [*3]);
  nput_c:  cover property (put_go ##[1:20] is_strm && OUT_LINK_FULL);
  cmp_c:   cover property (r.st == ST_EXEC && fn == FN_UNSIGNED_COMPARE);

endmodule
`default_nettype wire

/* ride_peer.sv */
// Stream link peer: a one-word slave slot and a master sink.
// Assumes the bench loads words and sets the full level.
`timescale 1ns/10ps
`default_nettype none
module ride_peer (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        LOAD,
  input  wire logic [31:0] LOAD_DATA,
  input  wire logic        LOAD_CTL,
  input  wire logic        FULL,
  input  wire logic        IN_READ,
  output logic      [31:0] IN_DATA,
  output logic             IN_WORD_IS_CONTROL,
  output logic             IN_WORD_AVAILABLE,
  input  wire logic [31:0] OUT_DATA,
  input  wire logic        OUT_IS_CONTROL,
  input  wire logic        OUT_WRITE,
  output logic             OUT_LINK_FULL,
  output logic      [31:0] SEEN_DATA,
  output logic             SEEN_CTL
);
  // Consumed slot shows inverted data so a stale word never passes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IN_DATA <= 32'h0;
      IN_WORD_IS_CONTROL <= 1'b0;
      IN_WORD_AVAILABLE <= 1'b0;
    end else if (LOAD) begin
      IN_DATA <= LOAD_DATA;
      IN_WORD_IS_CONTROL <= LOAD_CTL;
      IN_WORD_AVAILABLE <= 1'b1;
    end else if (IN_READ) begin
      IN_DATA <= ~IN_DATA;
      IN_WORD_IS_CONTROL <= ~IN_WORD_IS_CONTROL;
      IN_WORD_AVAILABLE <= 1'b0;
    end
  end
  assign OUT_LINK_FULL = FULL;
  // Sink keeps the last word written
  always_ff @(posedge CLK) begin
    if (OUT_WRITE) begin
      SEEN_DATA <= OUT_DATA;
      SEEN_CTL <= OUT_IS_CONTROL;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the decode/execute unit.
// Assumes the stream peer model and zero-wait APB answers.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ride_pkg::*;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, IN_DATA, OUT_DATA, seen_data, q, ld_data;
  logic        PREADY, PSLVERR, IN_READ, OUT_WRITE, OUT_IS_CONTROL;
  logic        IN_WORD_IS_CONTROL, IN_WORD_AVAILABLE, OUT_LINK_FULL;
  logic        seen_ctl, perr, mc;
  logic        ld = 1'b0;
  logic        ld_ctl = 1'b0;
  logic        full = 1'b0;
  logic [2:0]  STREAM_PORT_SELECT;
  integer      seed = 32'h529C;
  int          num_errors = 0;
  int          comparisons = 0;
  localparam logic [31:0] OPS [23] = '{32'h1000_0000, 32'h1400_0000,
    32'h1400_0001, 32'h1400_0003, 32'h4400_0400, 32'h4400_0200,
    32'h4400_0000, 32'h4800_0000, 32'h4800_0002, 32'h8000_0400,
    32'h9000_0001, 32'h9000_0021, 32'h9000_0041, 32'h4000_0000,
    32'h8000_0000, 32'h8400_0000, 32'h8800_0000, 32'h8C00_0000,
    32'h8800_0400, 32'h8C00_0400, 32'h9000_0060, 32'h9000_0061,
    32'h3000_8000};

  always #5 CLK = ~CLK;

  ride_core uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STREAM_PORT_SELECT(STREAM_PORT_SELECT), .IN_DATA(IN_DATA),
    .IN_WORD_IS_CONTROL(IN_WORD_IS_CONTROL),
    .IN_WORD_AVAILABLE(IN_WORD_AVAILABLE), .IN_READ(IN_READ),
    .OUT_DATA(OUT_DATA), .OUT_IS_CONTROL(OUT_IS_CONTROL),
    .OUT_WRITE(OUT_WRITE), .OUT_LINK_FULL(OUT_LINK_FULL));
  ride_peer peer (.CLK(CLK), .RST(RST), .LOAD(ld), .LOAD_DATA(ld_data),
    .LOAD_CTL(ld_ctl), .FULL(full), .IN_READ(IN_READ), .IN_DATA(IN_DATA),
    .IN_WORD_IS_CONTROL(IN_WORD_IS_CONTROL),
    .IN_WORD_AVAILABLE(IN_WORD_AVAILABLE), .OUT_DATA(OUT_DATA),
    .OUT_IS_CONTROL(OUT_IS_CONTROL), .OUT_WRITE(OUT_WRITE),
    .OUT_LINK_FULL(OUT_LINK_FULL), .SEEN_DATA(seen_data),
    .SEEN_CTL(seen_ctl));

  // ----------------------------------------
  // Bus tasks and reference model
  // ----------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask

  // Request is held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic setr(input logic [4:0] i, input logic [31:0] v);
    apb(1'b1, A_GSEL, {27'h0, i});
    apb(1'b1, A_GDATA, v);
  endtask

  task automatic getr(input logic [4:0] i);
    apb(1'b1, A_GSEL, {27'h0, i});
    apb(1'b0, A_GDATA, 32'h0);
  endtask

  // Poll busy; a hung unit ends the run
  task automatic wt();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 30);
    if (n >= 30) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic load(input logic [31:0] d, input logic c);
    ld_data <= d;
    ld_ctl <= c;
    ld <= 1'b1;
    @(posedge CLK);
    ld <= 1'b0;
  endtask

  // Vector bit 31 is label 0, so label 31 is the LSB
  function automatic logic [31:0] model(input logic [31:0] t, a, b);
    logic [31:0] r;
    r = 32'h0;
    case (t[31:26])
      6'h04: r = b + a;
      6'h05: begin
        r = b + ~a + 32'h1;
        if (t[1:0] == 2'h1)
          r[31] = !($signed(b) >= $signed(a));
        if (t[1:0] == 2'h3)
          r[31] = !(b >= a);
      end
      6'h11: r = t[10] ? a << b[4:0] : t[9] ?
        32'($signed(a) >>> b[4:0]) : a >> b[4:0];
      6'h0C: r = a + {{16{t[15]}}, t[15:0]};
      6'h10: r = a * b;
      6'h12: r = (a == 0) ? 32'h0 : t[1] ? b / a :
        32'($signed(b) / $signed(a));
      6'h20: if (!t[10])
          r = a | b;
        else
          for (int l = 3; l >= 0; l--)
            if (r == 0 && a[l*8+:8] == b[l*8+:8])
              r = 32'(4 - l);
      6'h21: r = a & b;
      6'h22: r = t[10] ? 32'(a == b) : a ^ b;
      6'h23: r = t[10] ? 32'(a != b) : a & ~b;
      6'h24: if (t[6:5] == 2'h3) begin
        r = t[0] ? {{16{a[15]}}, a[15:0]} : {{24{a[7]}}, a[7:0]};
      end else begin
        r = {t[6:5] == 2'h0 ? a[31] : t[6:5] == 2'h1 ? mc : 1'b0, a[31:1]};
        mc = a[0];
      end
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] a, b, t, e;
    mc = 1'b0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    setr(5'd0, $random(seed));
    getr(5'd0);
    chk("zero reg", 32'h0, q);
    // Arithmetic, shift, divide and byte find against the model
    for (int k = 0; k < 46; k++) begin
      t = OPS[k % 23];
      t = t | 32'h0061_0000 | (t[31:26] == 6'h24 ? 32'h0 : 32'h1000);
      a = $random(seed);
      b = $random(seed);
      if (t[31] && t[10])
        b = a ^ {16'hFFFF, 8'h00, b[7:0]};
      e = model(t, a, b);
      setr(5'd1, a);
      setr(5'd2, b);
      apb(1'b1, A_INSTR, t);
      wt();
      chk("carry", {31'h0, mc}, {31'h0, q[1]});
      getr(5'd3);
      chk("result", e, q);
    end
    // Blocking read stalls with no word, then completes on a data word
    apb(1'b1, A_INSTR, 32'h6C80_0003);
    repeat (3) @(posedge CLK);
    chk("port", 32'h3, {29'h0, STREAM_PORT_SELECT});
    apb(1'b0, A_STATUS, 32'h0);
    chk("stall", 32'h1, {31'h0, q[0]});
    // Each read kind with both markers; error when marker differs
    // Word is offered first so the non-blocking kinds find it
    for (int k = 0; k < 8; k++) begin
      a = $random(seed);
      load(a, k[2]);
      if (k > 0)
        apb(1'b1, A_INSTR, 32'h6C80_0003 | {k[1:0], 13'h0});
      if (k[1])
        mc = 1'b0;
      wt();
      chk("stream err", {31'h0, k[2] ^ k[0]}, {31'h0, q[2]});
      chk("carry", {31'h0, mc}, {31'h0, q[1]});
      getr(5'd4);
      chk("read word", a, q);
      apb(1'b1, A_STATUS, 32'h1C);
    end
    apb(1'b1, A_INSTR, 32'h6C80_4003);
    wt();
    chk("carry empty", 32'h1, {31'h0, q[1]});
    // Blocking write waits on full; non-blocking reports full in carry
    full <= 1'b1;
    b = $random(seed);
    setr(5'd1, b);
    apb(1'b1, A_INSTR, 32'h6C01_8005);
    repeat (3) @(posedge CLK);
    apb(1'b0, A_STATUS, 32'h0);
    chk("put waits", 32'h1, {31'h0, q[0]});
    full <= 1'b0;
    wt();
    chk("put data", b, seen_data);
    chk("put mark", 32'h0, {31'h0, seen_ctl});
    b = $random(seed);
    setr(5'd1, b);
    apb(1'b1, A_INSTR, 32'h6C01_A005);
    wt();
    chk("cput data", b, seen_data);
    chk("cput mark", 32'h1, {31'h0, seen_ctl});
    full <= 1'b1;
    apb(1'b1, A_INSTR, 32'h6C01_C005);
    wt();
    chk("nput full", 32'h1, {31'h0, q[1]});
    full <= 1'b0;
    // Disabled divider is refused and leaves its target alone
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_INSTR, 32'h4861_1000);
    wt();
    chk("div off", 32'h1, {31'h0, q[3]});
    getr(5'd3);
    chk("div keep", e, q);
    // Misaligned word load raises the alignment fault
    a = $random(seed) | 32'h1;
    setr(5'd1, a);
    setr(5'd2, 32'h0);
    apb(1'b1, A_INSTR, 32'hC861_1000);
    wt();
    chk("align", 32'h1, {31'h0, q[4]});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, q);
    tally_and_finish();
  end
endmodule
`default_nettype wire
